/* cfb_pkg.sv */
package cfb_pkg;

    // Sample, coefficient and accumulator widths of the equalizer datapath.
    localparam int CFB_SAMP_W   = 8;
    localparam int CFB_TAP_W    = 12;
    localparam int CFB_CTR_W    = 18;
    localparam int CFB_NTAPS    = 9;
    localparam int CFB_CTR_POS  = 4;
    localparam int CFB_OUT_W    = CFB_SAMP_W + CFB_CTR_W + 4;

    // Bus geometry; register indices are word numbers, byte address is four times the index.
    localparam int CFB_ADDR_W   = 16;
    localparam int CFB_IDX_W    = 11;
    localparam int CFB_REG_W    = 24;

    // Register indices of the first channel's coefficient set, tap 1 to tap 9.
    localparam logic [10:0] CFB_IDX_A [CFB_NTAPS] = '{
        11'h418, 11'h41a, 11'h41c, 11'h41e, 11'h420,
        11'h423, 11'h425, 11'h427, 11'h429
    };

    // Register indices of the second channel's coefficient set, tap 1 to tap 9.
    localparam logic [10:0] CFB_IDX_B [CFB_NTAPS] = '{
        11'h448, 11'h44a, 11'h44c, 11'h44e, 11'h450,
        11'h453, 11'h455, 11'h457, 11'h459
    };

    // Mode control and filter output status registers.
    localparam logic [10:0] CFB_IDX_MODE   = 11'h460;
    localparam logic [10:0] CFB_IDX_STAT_A = 11'h461;
    localparam logic [10:0] CFB_IDX_STAT_B = 11'h462;
    localparam int          CFB_SINGLE_BIT = 0;

    // Storage masks: side taps keep 16 bits, the center tap keeps 24 bits.
    localparam logic [23:0] CFB_MASK_SIDE = 24'h00ffff;
    localparam logic [23:0] CFB_MASK_CTR  = 24'hffffff;

    // Reset values.
    localparam logic [23:0] CFB_COEF_RST  = 24'h000000;
    localparam logic        CFB_MODE_RST  = 1'h0;

    // AXI response codes.
    localparam logic [1:0]  CFB_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  CFB_RESP_SLVERR = 2'h2;

endpackage : cfb_pkg

/* cfb_fir9.sv */
`timescale 1ns/1ps

// Nine-tap signed FIR with an eighteen-bit center tap and twelve-bit side taps.
module cfb_fir9
    import cfb_pkg::*;
#(
    parameter int SAMP_W = CFB_SAMP_W,
    parameter int TAP_W  = CFB_TAP_W,
    parameter int CTR_W  = CFB_CTR_W,
    parameter int OUT_W  = CFB_OUT_W
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       nrst_i,
    input  wire logic signed [SAMP_W-1:0]   samp_i,
    input  wire logic                       samp_vld_i,
    input  wire logic        [8*TAP_W-1:0]  side_i,
    input  wire logic signed [CTR_W-1:0]    ctr_i,
    output logic signed      [OUT_W-1:0]    y_o,
    output logic                            y_vld_o
);

    logic signed [SAMP_W-1:0] dly_r [CFB_NTAPS];
    logic                     calc_r;
    logic signed [OUT_W-1:0]  acc;

    // Delay line of the nine newest samples; index 0 is the newest.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            for (int k = 0; k < CFB_NTAPS; k++) begin
                dly_r[k] <= '0;
            end
        end else if (samp_vld_i) begin
            dly_r[0] <= samp_i;
            for (int k = 1; k < CFB_NTAPS; k++) begin
                dly_r[k] <= dly_r[k-1];
            end
        end
    end

    // Signed multiply-accumulate; four guard bits cover the sum of nine products.
    always_comb begin
        acc = '0;
        for (int k = 0; k < CFB_NTAPS; k++) begin
            if (k == CFB_CTR_POS) begin
                // Operands are widened first so the product never wraps at a narrow width.
                acc = acc + OUT_W'(dly_r[k]) * OUT_W'(ctr_i);
            end else if (k < CFB_CTR_POS) begin
                acc = acc + OUT_W'(dly_r[k]) *
                      OUT_W'($signed(side_i[k*TAP_W +: TAP_W]));
            end else begin
                acc = acc + OUT_W'(dly_r[k]) *
                      OUT_W'($signed(side_i[(k-1)*TAP_W +: TAP_W]));
            end
        end
    end

    // The sum is registered one cycle after the delay line moves.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            calc_r  <= 1'b0;
            y_o     <= '0;
            y_vld_o <= 1'b0;
        end else begin
            calc_r  <= samp_vld_i;
            y_vld_o <= calc_r;
            if (calc_r) begin
                y_o <= acc;
            end
        end
    end

endmodule : cfb_fir9

/* cfb_coef_bank.sv */
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

module cfb_coef_bank
    import cfb_pkg::*;
#(
    parameter int SAMP_W = CFB_SAMP_W,
    parameter int ADDR_W = CFB_ADDR_W
) (
    input  wire logic                      sys_clk_i,
    input  wire logic                      nrst_i,
    // AXI4-Lite write address channel.
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output logic                           s_axi_awready_o,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]               s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output logic                           s_axi_wready_o,
    // AXI4-Lite write response channel.
    output logic [1:0]                     s_axi_bresp_o,
    output logic                           s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    // AXI4-Lite read address channel.
    input  wire logic [ADDR_W-1:0]         s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output logic                           s_axi_arready_o,
    // AXI4-Lite read data channel.
    output logic [31:0]                    s_axi_rdata_o,
    output logic [1:0]                     s_axi_rresp_o,
    output logic                           s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i,
    // Converter sample streams.
    input  wire logic signed [SAMP_W-1:0]  samp_a_i,
    input  wire logic                      samp_a_vld_i,
    input  wire logic signed [SAMP_W-1:0]  samp_b_i,
    input  wire logic                      samp_b_vld_i,
    // Equalized outputs.
    output logic signed [CFB_OUT_W-1:0]    eq_a_o,
    output logic                           eq_a_vld_o,
    output logic signed [CFB_OUT_W-1:0]    eq_b_o,
    output logic                           eq_b_vld_o
);

    // Coefficient storage: row 0 is the first channel, row 1 the second.
    logic [CFB_REG_W-1:0]  coef_r [2][CFB_NTAPS];
    logic                  single_mode_r;

    // Write path holding registers.
    logic                  aw_held_r;
    logic [CFB_IDX_W-1:0]  aw_idx_r;
    logic                  w_held_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic                  aw_take;
    logic                  w_take;
    logic                  do_write;
    logic                  aw_held_nxt;
    logic                  w_held_nxt;

    // Read path.
    logic                  ar_take;
    logic [CFB_IDX_W-1:0]  ar_idx;
    logic [31:0]           rd_data;
    logic                  rd_hit;

    // Write decode results.
    logic                  wr_hit;
    logic                  wr_coef;
    logic                  wr_chan;
    int                    wr_tap;
    logic [31:0]           wr_merge;

    // Filter side tap vectors and center taps.
    logic [8*CFB_TAP_W-1:0]      side_a;
    logic [8*CFB_TAP_W-1:0]      side_b;
    logic signed [CFB_CTR_W-1:0] ctr_a;
    logic signed [CFB_CTR_W-1:0] ctr_b;

    // Filter results before the output registers.
    logic signed [CFB_OUT_W-1:0] y_a;
    logic                        y_a_vld;
    logic signed [CFB_OUT_W-1:0] y_b;
    logic                        y_b_vld;

    // Last result of each filter, readable by software.
    logic signed [CFB_OUT_W-1:0] last_a_r;
    logic signed [CFB_OUT_W-1:0] last_b_r;

    // Handshake terms; only the held copies feed the register write.
    assign aw_take  = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take   = s_axi_wvalid_i && s_axi_wready_o;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid_o;

    always_comb begin
        aw_held_nxt = aw_held_r ? !do_write : aw_take;
        w_held_nxt  = w_held_r ? !do_write : w_take;
    end

    // Address and data are captured independently, in either order.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            aw_held_r       <= 1'b0;
            w_held_r        <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            aw_idx_r        <= '0;
            wdata_r         <= '0;
            wstrb_r         <= '0;
        end else begin
            aw_held_r       <= aw_held_nxt;
            w_held_r        <= w_held_nxt;
            s_axi_awready_o <= !aw_held_nxt;
            s_axi_wready_o  <= !w_held_nxt;
            if (aw_take) begin
                aw_idx_r <= s_axi_awaddr_i[CFB_IDX_W+1:2];
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
        end
    end

    // Decode the held write index against both coefficient tables.
    always_comb begin
        wr_hit  = 1'b0;
        wr_coef = 1'b0;
        wr_chan = 1'b0;
        wr_tap  = 0;
        for (int k = 0; k < CFB_NTAPS; k++) begin
            if (aw_idx_r == CFB_IDX_A[k]) begin
                wr_coef = 1'b1;
                wr_chan = 1'b0;
                wr_tap  = k;
            end
            if (aw_idx_r == CFB_IDX_B[k]) begin
                wr_coef = 1'b1;
                wr_chan = 1'b1;
                wr_tap  = k;
            end
        end
        wr_hit = wr_coef || (aw_idx_r == CFB_IDX_MODE) ||
                 (aw_idx_r == CFB_IDX_STAT_A) || (aw_idx_r == CFB_IDX_STAT_B);
    end

    // Merge the strobed bytes over the present contents of the target.
    always_comb begin
        wr_merge = {8'h00, coef_r[wr_chan][wr_tap]};
        for (int b = 0; b < 4; b++) begin
            if (wstrb_r[b]) begin
                wr_merge[8*b +: 8] = wdata_r[8*b +: 8];
            end
        end
    end

    // Coefficient storage; reserved bits under the storage mask are kept as written, as read/write cells; side tap bits 23:16 are cleared.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < CFB_NTAPS; k++) begin
                    coef_r[c][k] <= CFB_COEF_RST;
                end
            end
        end else if (do_write && wr_coef) begin
            if (wr_tap == CFB_CTR_POS) begin
                coef_r[wr_chan][wr_tap] <= wr_merge[23:0] & CFB_MASK_CTR;
            end else begin
                coef_r[wr_chan][wr_tap] <= wr_merge[23:0] & CFB_MASK_SIDE;
            end
        end
    end

    // Mode control: bit 0 selects single channel operation; the second filter halts.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            single_mode_r <= CFB_MODE_RST;
        end else if (do_write && aw_idx_r == CFB_IDX_MODE && wstrb_r[0]) begin
            single_mode_r <= wdata_r[CFB_SINGLE_BIT];
        end
    end

    // Write response; status registers accept writes but ignore them.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= CFB_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? CFB_RESP_OKAY : CFB_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read decode straight from the offered address.
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
    assign ar_idx  = s_axi_araddr_i[CFB_IDX_W+1:2];

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b0;
        for (int k = 0; k < CFB_NTAPS; k++) begin
            if (ar_idx == CFB_IDX_A[k]) begin
                rd_data = {8'h00, coef_r[0][k]};
                rd_hit  = 1'b1;
            end
            if (ar_idx == CFB_IDX_B[k]) begin
                rd_data = {8'h00, coef_r[1][k]};
                rd_hit  = 1'b1;
            end
        end
        if (ar_idx == CFB_IDX_MODE) begin
            rd_data = {31'h0, single_mode_r};
            rd_hit  = 1'b1;
        end
        if (ar_idx == CFB_IDX_STAT_A) begin
            rd_data = 32'(last_a_r);
            rd_hit  = 1'b1;
        end
        if (ar_idx == CFB_IDX_STAT_B) begin
            rd_data = 32'(last_b_r);
            rd_hit  = 1'b1;
        end
    end

    // Read channel: one read in flight, answered on the cycle after the take.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= CFB_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_data;
            s_axi_rresp_o   <= rd_hit ? CFB_RESP_OKAY : CFB_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
        end
    end

    // Pack the coefficient fields; only the documented field bits reach the filters.
    always_comb begin
        side_a = '0;
        side_b = '0;
        for (int k = 0; k < CFB_NTAPS; k++) begin
            if (k < CFB_CTR_POS) begin
                side_a[k*CFB_TAP_W +: CFB_TAP_W] = coef_r[0][k][CFB_TAP_W-1:0];
                side_b[k*CFB_TAP_W +: CFB_TAP_W] = coef_r[1][k][CFB_TAP_W-1:0];
            end else if (k > CFB_CTR_POS) begin
                side_a[(k-1)*CFB_TAP_W +: CFB_TAP_W] = coef_r[0][k][CFB_TAP_W-1:0];
                side_b[(k-1)*CFB_TAP_W +: CFB_TAP_W] = coef_r[1][k][CFB_TAP_W-1:0];
            end
        end
        ctr_a = $signed(coef_r[0][CFB_CTR_POS][CFB_CTR_W-1:0]);
        ctr_b = $signed(coef_r[1][CFB_CTR_POS][CFB_CTR_W-1:0]);
    end

    // First filter: the first channel set serves it in both modes.
    cfb_fir9 #(
        .SAMP_W (SAMP_W),
        .TAP_W  (CFB_TAP_W),
        .CTR_W  (CFB_CTR_W),
        .OUT_W  (CFB_OUT_W)
    ) u_fir_a (
        .sys_clk_i  (sys_clk_i),
        .nrst_i     (nrst_i),
        .samp_i     (samp_a_i),
        .samp_vld_i (samp_a_vld_i),
        .side_i     (side_a),
        .ctr_i      (ctr_a),
        .y_o        (y_a),
        .y_vld_o    (y_a_vld)
    );

    // Second filter runs only in dual mode, on its own coefficient set.
    cfb_fir9 #(
        .SAMP_W (SAMP_W),
        .TAP_W  (CFB_TAP_W),
        .CTR_W  (CFB_CTR_W),
        .OUT_W  (CFB_OUT_W)
    ) u_fir_b (
        .sys_clk_i  (sys_clk_i),
        .nrst_i     (nrst_i),
        .samp_i     (samp_b_i),
        .samp_vld_i (samp_b_vld_i && !single_mode_r),
        .side_i     (side_b),
        .ctr_i      (ctr_b),
        .y_o        (y_b),
        .y_vld_o    (y_b_vld)
    );

    // Output registers; in single mode the second output stays silent.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            eq_a_o     <= '0;
            eq_a_vld_o <= 1'b0;
            eq_b_o     <= '0;
            eq_b_vld_o <= 1'b0;
        end else begin
            eq_a_o     <= y_a;
            eq_a_vld_o <= y_a_vld;
            eq_b_o     <= y_b;
            eq_b_vld_o <= y_b_vld && !single_mode_r;
        end
    end

    // Latest results kept for software; a stale value is harmless since it is only a monitor.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            last_a_r <= '0;
            last_b_r <= '0;
        end else begin
            if (y_a_vld) begin
                last_a_r <= y_a;
            end
            if (y_b_vld) begin
                last_b_r <= y_b;
            end
        end
    end

endmodule : cfb_coef_bank

/* cfb_coef_bank_assertions.sv */
`timescale 1ns/1ps

// Watches the register bus and the equalizer strobes of the coefficient bank.
module cfb_coef_bank_chk
    import cfb_pkg::*;
#(
    parameter int ADDR_W = CFB_ADDR_W
) (
    input wire logic              sys_clk_i,
    input wire logic              nrst_i,
    input wire logic              s_axi_awvalid_i,
    input wire logic              s_axi_awready_o,
    input wire logic              s_axi_wvalid_i,
    input wire logic              s_axi_wready_o,
    input wire logic [1:0]        s_axi_bresp_o,
    input wire logic              s_axi_bvalid_o,
    input wire logic              s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic              s_axi_arvalid_i,
    input wire logic              s_axi_arready_o,
    input wire logic [31:0]       s_axi_rdata_o,
    input wire logic [1:0]        s_axi_rresp_o,
    input wire logic              s_axi_rvalid_o,
    input wire logic              samp_a_vld_i,
    input wire logic              samp_b_vld_i,
    input wire logic [29:0]       eq_a_o,
    input wire logic              eq_a_vld_o,
    input wire logic              eq_b_vld_o
);
    logic [10:0] ar_idx_r;
    logic        side_rd;

    // The read address may move after its take, so the index is kept here.
    always_ff @(posedge sys_clk_i) begin
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            ar_idx_r <= s_axi_araddr_i[12:2];
        end
    end

    // Side taps of the upper half keep only sixteen bits.
    assign side_rd = ar_idx_r inside {CFB_IDX_A[5], CFB_IDX_A[6], CFB_IDX_A[7], CFB_IDX_A[8]};

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_eq_a_delay: assert property (samp_a_vld_i |-> ##3 eq_a_vld_o)
        else $error("filter A output late or missing");
    a_eq_a_cause: assert property (eq_a_vld_o |-> $past(samp_a_vld_i, 3))
        else $error("filter A output without a sample");
    a_eq_b_cause: assert property (eq_b_vld_o |-> $past(samp_b_vld_i, 3))
        else $error("filter B output without a sample");
    a_eq_a_hold: assert property (!eq_a_vld_o |-> $stable(eq_a_o))
        else $error("filter A output moved between results");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o && !s_axi_bvalid_o |-> ##2 s_axi_bvalid_o)
        else $error("write response not on time");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read data not on time");
    a_err_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == CFB_RESP_SLVERR |->
        s_axi_rdata_o == 32'h0)
        else $error("refused read returned data");
    a_side_width: assert property (s_axi_rvalid_o && side_rd |-> s_axi_rdata_o[31:16] == 16'h0)
        else $error("side tap read wider than sixteen bits");
    a_ctr_width: assert property (s_axi_rvalid_o && ar_idx_r == CFB_IDX_A[4] |->
        s_axi_rdata_o[31:24] == 8'h0)
        else $error("center tap read wider than 24 bits");

    c_eq_a: cover property (eq_a_vld_o);
    c_eq_b: cover property (eq_b_vld_o);
    c_rd_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == CFB_RESP_SLVERR);
endmodule : cfb_coef_bank_chk

bind cfb_coef_bank cfb_coef_bank_chk #(.ADDR_W(ADDR_W)) chk_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .samp_a_vld_i(samp_a_vld_i),
    .samp_b_vld_i(samp_b_vld_i), .eq_a_o(eq_a_o),
    .eq_a_vld_o(eq_a_vld_o), .eq_b_vld_o(eq_b_vld_o));

/* tb.sv */
`timescale 1ns/1ps

// Register access over AXI4-Lite and impulse responses of both filters.
module tb;
    import cfb_pkg::*;
    logic                  sys_clk_i = 1'b0;
    logic                  nrst_i = 1'b0;
    logic [15:0]           awaddr = 16'h0, araddr = 16'h0;
    logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                  arvalid = 1'b0, rready = 1'b0, sav = 1'b0, sbv = 1'b0;
    logic [31:0]           wdata = 32'h0, rd;
    logic [3:0]            wstrb = 4'hf;
    logic [7:0]            sa = 8'h0, sb = 8'h0;
    logic [1:0]            rs;
    wire logic             awready, wready, bvalid, arready, rvalid, eqav, eqbv;
    wire logic [1:0]       bresp, rresp;
    wire logic [31:0]      rdata;
    wire logic [29:0]      eqa, eqb;
    int                    mismatches = 0, n_checks = 0;
    int                    ca [9], cb [9];

    // Free-running 125 MHz clock.
    always #4 sys_clk_i = ~sys_clk_i;

    cfb_coef_bank cfb_coef_bank_i (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .samp_a_i(sa), .samp_a_vld_i(sav), .samp_b_i(sb), .samp_b_vld_i(sbv),
        .eq_a_o(eqa), .eq_a_vld_o(eqav), .eq_b_o(eqb), .eq_b_vld_o(eqbv));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic hang_out;
        mismatches++;
        $display("[FAIL] %0t no answer", $time);
        print_verdict();
    endtask : hang_out

    // Offers address and data together; each is released at its own take.
    task automatic axw(input int idx, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_i);
        awaddr <= 16'(idx * 4);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge sys_clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang_out();
    endtask : axw

    task automatic axr(input int idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_i);
        araddr <= 16'(idx * 4);
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge sys_clk_i);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hang_out();
    endtask : axr

    // Every tap of the first set reads zero after reset.
    task automatic reg_reset_check;
        for (int k = 0; k < 9; k++) begin
            axr(int'(CFB_IDX_A[k]), rd, rs);
            chk(rd, 32'h0);
            chk({30'h0, rs}, {30'h0, CFB_RESP_OKAY});
        end
    endtask : reg_reset_check

    // All-ones writes show the stored width; an unmapped index is refused.
    task automatic reg_width_check;
        for (int k = 0; k < 9; k++) begin
            axw(int'(CFB_IDX_A[k]), 32'hffff_ffff, rs);
            axr(int'(CFB_IDX_A[k]), rd, rs);
            chk(rd, (k == 4) ? 32'h00ff_ffff : 32'h0000_ffff);
        end
        axw(int'(11'h421), 32'h1234, rs);
        chk({30'h0, rs}, {30'h0, CFB_RESP_SLVERR});
        axr(int'(11'h421), rd, rs);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, CFB_RESP_SLVERR});
    endtask : reg_width_check

    // Reserved bits are set on purpose; they must not reach the filters.
    task automatic load_coefs;
        logic [31:0] wa;
        logic [31:0] wb;
        for (int k = 0; k < 9; k++) begin
            wa = (k == 4) ? 32'hfffe_0003 : (32'hffff_f800 | 32'(k * 81));
            wb = (k == 4) ? 32'h0001_fff0 : (32'h0000_9010 + 32'(k * 51));
            ca[k] = (k == 4) ? int'($signed(wa[17:0])) : int'($signed(wa[11:0]));
            cb[k] = (k == 4) ? int'($signed(wb[17:0])) : int'($signed(wb[11:0]));
            axw(int'(CFB_IDX_A[k]), wa, rs);
            axw(int'(CFB_IDX_B[k]), wb, rs);
        end
    endtask : load_coefs

    // An impulse on each stream walks out the taps from first to ninth; in single mode the second output is checked silent.
    task automatic fir_run(input logic single_mode);
        int i;
        for (int j = 0; j < 9; j++) begin
            @(posedge sys_clk_i);
            sa <= (j == 0) ? 8'h80 : 8'h00;
            sb <= (j == 0) ? 8'h7f : 8'h00;
            sav <= 1'b1;
            sbv <= 1'b1;
            @(posedge sys_clk_i);
            sav <= 1'b0;
            sbv <= 1'b0;
            for (i = 0; i < 10; i++) begin
                @(posedge sys_clk_i);
                if (eqav === 1'b1) break;
            end
            if (i == 10) hang_out();
            chk({{2{eqa[29]}}, eqa}, 32'(-128 * ca[j]));
            if (single_mode) begin
                chk({31'h0, eqbv}, 32'h0);
            end else begin
                chk({31'h0, eqbv}, 32'h1);
                chk({{2{eqb[29]}}, eqb}, 32'(127 * cb[j]));
            end
        end
        // The status word keeps the last result of the first filter, sign-extended.
        axr(int'(CFB_IDX_STAT_A), rd, rs);
        chk(rd, 32'(-128 * ca[8]));
    endtask : fir_run

    // Main sequence: reset, registers, dual mode, then single mode.
    initial begin
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        reg_reset_check();
        reg_width_check();
        load_coefs();
        fir_run(1'b0);
        axw(int'(CFB_IDX_MODE), 32'h1, rs);
        fir_run(1'b1);
        print_verdict();
    end
endmodule : tb
